/* hdl/sac_pkg.sv */
// package: register map, field layout, timing and types of the sar converter control
package sac_pkg;

    // ------------------------------------------------------------
    // register offsets (plain 8-bit address space)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_A = 8'h0E;
    localparam logic [7:0] OFF_CTRL_B = 8'h0F;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_RESULT = 8'h21;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_A_RESET = 8'h10;
    localparam logic [5:0] CTRL_B_RESET = 6'h10;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CA_START_BIT = 7;
    localparam int CA_DIS_BIT   = 4;
    localparam int CA_CH_LSB    = 0;
    localparam int CB_TIME_LSB  = 1;
    localparam int CB_REF_BIT   = 5;
    localparam int ST_DONE_BIT  = 5;
    localparam int ST_BUSY_BIT  = 4;

    // ------------------------------------------------------------
    // channel and conversion time codes
    // ------------------------------------------------------------
    localparam logic [3:0] CH_IN1 = 4'h1;
    localparam logic [3:0] CH_IN2 = 4'h2;
    localparam logic [3:0] CH_IN3 = 4'h3;
    localparam logic [3:0] CH_IN4 = 4'h4;

    localparam logic [2:0] TC_39   = 3'h0;
    localparam logic [2:0] TC_78   = 3'h2;
    localparam logic [2:0] TC_156  = 3'h3;
    localparam logic [2:0] TC_312  = 3'h4;
    localparam logic [2:0] TC_624  = 3'h5;
    localparam logic [2:0] TC_1248 = 3'h6;

    localparam logic [10:0] CYC_39   = 11'd39;
    localparam logic [10:0] CYC_78   = 11'd78;
    localparam logic [10:0] CYC_156  = 11'd156;
    localparam logic [10:0] CYC_312  = 11'd312;
    localparam logic [10:0] CYC_624  = 11'd624;
    localparam logic [10:0] CYC_1248 = 11'd1248;

    // one comparison step lasts the total divided by 2**STEP_SHIFT, plus one cycle
    localparam int STEP_SHIFT = 4;

    // reserved codes fall back to the slowest setting, the safest one
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        logic [10:0] n;
        n = CYC_1248;
        unique case (code)
            TC_39:   n = CYC_39;
            TC_78:   n = CYC_78;
            TC_156:  n = CYC_156;
            TC_312:  n = CYC_312;
            TC_624:  n = CYC_624;
            default: n = CYC_1248;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sac_bus_req_t;

    typedef struct packed {
        logic       sample;
        logic [3:0] chan_en;
        logic [7:0] trial;
        logic       ref_on;
        logic       inputs_off;
    } sac_ana_t;

    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b001,
        SEQ_SAMPLE  = 3'b010,
        SEQ_COMPARE = 3'b100
    } sac_seq_state_t;

endpackage

/* hdl/sac_sync.sv */
// two-flop synchroniser for levels entering the clk domain
`timescale 1ns/1ps
`default_nettype none

module sac_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

/* hdl/sac_top.sv */
// sar converter control: registers, sequencer, flags and analog-side controls
//
// Functional notes
// R1 - one 8-bit channel, successive approximation, one 8-bit code per conversion
// R2 - writing one to start bit 7 begins conversion; bit clears itself
// R3 - channel codes 1..4 select inputs 1..4; others reserved; reset reserved
// R4 - input disable bit: zero enables analog inputs, one disables them
// R5 - software changes channel only while busy flag is zero
// R6 - software never restarts during conversion; waits for done or interrupt
// R7 - low-power mode resets control register a and blocks its writes
// R8 - low-power mode resets control register b and blocks its writes
// R9 - software writes one to bit 5, zero to bit 6 of register a
// R10 - software writes zero to bit 0, one to bit 4 of register b
// R11 - bits 6 and 7 of register b read undefined; tests mask them
// R12 - time codes give 39,78,156,312,624,1248 cycles; 001 and 111 reserved
// R13 - result holds 8-bit code, msb at bit 7, resets to zero
// R14 - done flag reads one after completion; result read clears it
// R15 - software reads status before result, since result read clears done
// R16 - busy set at start, cleared at finish, forced zero in stop or slow
// R17 - status bits 7, 6 and 3..0 are meaningless on read
// R18 - completion loads result, sets done and pulses interrupt together
// R19 - new start clears done; result keeps old value until new finish
// R20 - sequencer samples, then resolves eight bits msb first within the time
// R21 - low-power entry aborts conversion at once; done never set for it
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sac_top (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire sac_pkg::sac_bus_req_t bus_req,
    output logic [7:0]                 rd_data,
    input  wire logic                  stop_mode,
    input  wire logic                  slow_mode,
    input  wire logic                  sleep_mode,
    input  wire logic                  comp_in,
    output sac_pkg::sac_ana_t          ana,
    output logic                       conv_complete_irq
);
    import sac_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]     ctrl_a_reg;
    logic [5:0]     ctrl_b_reg;
    logic [7:0]     result_reg;
    logic           done_flag_reg;
    logic           irq_reg;
    logic [7:0]     rd_data_reg;
    logic [3:0]     chan_en_reg;
    sac_seq_state_t state_reg;
    logic [10:0]    cnt_reg;
    logic [2:0]     bit_idx_reg;
    logic [7:0]     trial_reg;
    logic [6:0]     step_reg;

    logic           comp_sync;
    logic           lp_any;
    logic           wr_ctrl_a;
    logic           wr_ctrl_b;
    logic           rd_result;
    logic           start_go;
    logic           busy;
    logic           finish;
    logic [10:0]    total_cycles;
    logic [6:0]     step_len;
    logic [10:0]    sample_len;
    logic [7:0]     decided;
    logic [3:0]     channel_select;
    logic           analog_input_disable;
    logic [2:0]     time_code;

    // ------------------------------------------------------------
    // comparator input crossing
    // ------------------------------------------------------------
    // the comparator settles asynchronously; two flops before use
    sac_sync #(
        .WIDTH (1)
    ) u_comp_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (comp_in),
        .sync_out (comp_sync)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // mode levels come from this clock domain, so no synchroniser
    assign lp_any    = stop_mode | slow_mode | sleep_mode;
    assign wr_ctrl_a = bus_req.wr && (bus_req.addr == OFF_CTRL_A);
    assign wr_ctrl_b = bus_req.wr && (bus_req.addr == OFF_CTRL_B);
    assign rd_result = bus_req.rd && (bus_req.addr == OFF_RESULT);

    assign channel_select       = ctrl_a_reg[CA_CH_LSB +: 4];
    assign analog_input_disable = ctrl_a_reg[CA_DIS_BIT];
    assign time_code            = ctrl_b_reg[CB_TIME_LSB +: 3];

    // a pending trigger is only honoured in a normal run mode
    assign start_go = ctrl_a_reg[CA_START_BIT] & ~lp_any;
    assign busy     = (state_reg != SEQ_IDLE);

    // ------------------------------------------------------------
    // control register a
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_reg <= CTRL_A_RESET;
        end else if (lp_any) begin
            ctrl_a_reg <= CTRL_A_RESET; // [R7]
        end else if (wr_ctrl_a) begin
            ctrl_a_reg <= bus_req.wdata; // [R3] [R4]
        end else if (start_go) begin
            ctrl_a_reg[CA_START_BIT] <= 1'b0; // [R2]
        end
    end

    // ------------------------------------------------------------
    // control register b
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_b_reg <= CTRL_B_RESET;
        end else if (lp_any) begin
            ctrl_b_reg <= CTRL_B_RESET; // [R8]
        end else if (wr_ctrl_b) begin
            ctrl_b_reg <= bus_req.wdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    assign total_cycles = conv_cycles(time_code); // [R12]
    // plus one: the synchronised comparator needs three edges after a trial
    assign step_len     = total_cycles[STEP_SHIFT +: 7] + 7'd1; // [R20]
    // sampling takes what the eight comparison steps leave over
    assign sample_len   = total_cycles - {1'b0, step_len, 3'b000}; // [R20]

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SEQ_IDLE;
        end else if (lp_any) begin
            state_reg <= SEQ_IDLE; // [R21] [R16]
        end else if (start_go) begin
            state_reg <= SEQ_SAMPLE; // [R16]
        end else begin
            unique case (state_reg)
                SEQ_IDLE: begin
                    state_reg <= SEQ_IDLE;
                end
                SEQ_SAMPLE: begin
                    if (cnt_reg == 11'd0) begin
                        state_reg <= SEQ_COMPARE;
                    end
                end
                SEQ_COMPARE: begin
                    if (finish) begin
                        state_reg <= SEQ_IDLE; // [R16]
                    end
                end
                default: begin
                    state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // step length
    // ------------------------------------------------------------
    // latched at start so a late time change cannot skew a running conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_reg <= 7'd0;
        end else if (start_go) begin
            step_reg <= step_len;
        end
    end

    // ------------------------------------------------------------
    // step counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 11'd0;
        end else if (lp_any) begin
            cnt_reg <= 11'd0;
        end else if (start_go) begin
            cnt_reg <= sample_len - 11'd1; // [R20]
        end else if (busy) begin
            if (cnt_reg == 11'd0) begin
                cnt_reg <= {4'h0, step_reg} - 11'd1;
            end else begin
                cnt_reg <= cnt_reg - 11'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // successive approximation
    // ------------------------------------------------------------
    // comparator high means input at or above the ladder: keep the bit
    always_comb begin
        decided = trial_reg & ~(8'h01 << bit_idx_reg);
        decided = decided | ({7'h00, comp_sync} << bit_idx_reg); // [R1]
    end

    // an abort or restart in the last step must not publish a result
    assign finish = (state_reg == SEQ_COMPARE) && (cnt_reg == 11'd0)
                    && (bit_idx_reg == 3'd0) && !lp_any && !start_go;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trial_reg   <= 8'h00;
            bit_idx_reg <= 3'd7;
        end else if (lp_any || start_go) begin
            trial_reg   <= 8'h00;
            bit_idx_reg <= 3'd7;
        end else if (cnt_reg == 11'd0) begin
            if (state_reg == SEQ_SAMPLE) begin
                trial_reg   <= 8'h80; // [R20]
                bit_idx_reg <= 3'd7;
            end else if (state_reg == SEQ_COMPARE) begin
                if (bit_idx_reg == 3'd0) begin
                    trial_reg <= 8'h00;
                end else begin
                    trial_reg   <= decided | (8'h01 << (bit_idx_reg - 3'd1)); // [R20]
                    bit_idx_reg <= bit_idx_reg - 3'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    // earlier results are wiped on low-power entry; read them before
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= RESULT_RESET; // [R13]
        end else if (lp_any) begin
            result_reg <= RESULT_RESET; // [R21]
        end else if (finish) begin
            result_reg <= decided; // [R18] [R19]
        end
    end

    // ------------------------------------------------------------
    // done flag and completion pulse
    // ------------------------------------------------------------
    // completion wins over a result read in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_flag_reg <= 1'b0;
        end else if (finish) begin
            done_flag_reg <= 1'b1; // [R18] [R14]
        end else if (rd_result || start_go || lp_any) begin
            done_flag_reg <= 1'b0; // [R14] [R19] [R21]
        end
    end

    // one-cycle request, in the cycle in which done first reads one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= finish; // [R18]
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // meaningless status bits and the top of register b read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFF_CTRL_A: begin
                    rd_data_reg <= ctrl_a_reg;
                end
                OFF_CTRL_B: begin
                    rd_data_reg <= {2'b00, ctrl_b_reg}; // [R11]
                end
                OFF_STATUS: begin
                    rd_data_reg <= 8'h00; // [R17]
                    rd_data_reg[ST_DONE_BIT] <= done_flag_reg; // [R14]
                    rd_data_reg[ST_BUSY_BIT] <= busy; // [R16]
                end
                OFF_RESULT: begin
                    rd_data_reg <= result_reg; // [R13]
                end
                default: begin
                    rd_data_reg <= 8'h00;
                end
            endcase
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // analog-side channel enables
    // ------------------------------------------------------------
    // reserved codes and the disable bit leave every input switch open
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_en_reg <= 4'h0;
        end else if (analog_input_disable) begin
            chan_en_reg <= 4'h0; // [R4]
        end else begin
            unique case (channel_select)
                CH_IN1:  chan_en_reg <= 4'h1; // [R3]
                CH_IN2:  chan_en_reg <= 4'h2;
                CH_IN3:  chan_en_reg <= 4'h4;
                CH_IN4:  chan_en_reg <= 4'h8;
                default: chan_en_reg <= 4'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ana.sample     = state_reg[1];
    assign ana.chan_en    = chan_en_reg;
    assign ana.trial      = trial_reg;
    assign ana.ref_on     = ctrl_b_reg[CB_REF_BIT];
    assign ana.inputs_off = ctrl_a_reg[CA_DIS_BIT];

    assign rd_data           = rd_data_reg;
    assign conv_complete_irq = irq_reg;

endmodule

`default_nettype wire

/* verification/sac_ana_model.sv */
// partner model: four analog inputs behind one sample-and-hold and a comparator
`timescale 1ns/1ps
`default_nettype none

module sac_ana_model
    import sac_pkg::*;
#(
    parameter logic [31:0] VOLTS = 32'h0000_0000
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire sac_pkg::sac_ana_t ana,
    output logic                   comp_in
);
    // ------------------------------------------------------------
    // sample and hold
    // ------------------------------------------------------------
    logic [7:0] held;

    // an unselected or disabled input floats: held level wanders every sampling cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= 8'h00;
        end else if (ana.sample) begin
            if (ana.inputs_off) begin
                held <= ~held;
            end else begin
                case (ana.chan_en)
                    4'h1:    held <= VOLTS[7:0];
                    4'h2:    held <= VOLTS[15:8];
                    4'h4:    held <= VOLTS[23:16];
                    4'h8:    held <= VOLTS[31:24];
                    default: held <= ~held;
                endcase
            end
        end
    end

    // comparator is asynchronous; the block synchronises it itself
    assign comp_in = (held >= ana.trial);
endmodule

`default_nettype wire

/* verification/sac_chk.sv */
// checker: port-level timing relations of the converter control
`timescale 1ns/1ps
`default_nettype none

module sac_chk (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire sac_pkg::sac_bus_req_t bus_req,
    input wire logic [7:0]            rd_data,
    input wire logic                  stop_mode,
    input wire logic                  slow_mode,
    input wire logic                  sleep_mode,
    input wire logic                  comp_in,
    input wire sac_pkg::sac_ana_t     ana,
    input wire logic                  conv_complete_irq
);
    import sac_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    logic lp;
    assign lp = stop_mode | slow_mode | sleep_mode;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_irq_one_pulse: assert property (
        conv_complete_irq |=> !conv_complete_irq) else $error("irq pulse too long");
    a_status_spare_zero: assert property (
        bus_req.rd && bus_req.addr == OFF_STATUS |=> (rd_data & 8'hCF) == 8'h00)
        else $error("status spare bits not zero");
    a_disable_follows: assert property (
        bus_req.wr && bus_req.addr == OFF_CTRL_A && !lp
        |=> ana.inputs_off == $past(bus_req.wdata[CA_DIS_BIT]))
        else $error("input disable does not follow write");
    a_lp_inputs_off: assert property (
        lp |=> ana.inputs_off) else $error("control a not reset in low power");
    a_lp_ref_off: assert property (
        lp |=> !ana.ref_on) else $error("control b not reset in low power");
    a_lp_no_irq: assert property (
        lp |=> !conv_complete_irq) else $error("irq raised in low power");
    a_start_samples: assert property (
        (bus_req.wr && bus_req.addr == OFF_CTRL_A && bus_req.wdata[7] && !lp) ##1 !lp
        |=> ana.sample) else $error("start did not begin sampling");
    a_msb_first: assert property (
        $fell(ana.sample) && !$past(lp) |-> ana.trial == 8'h80)
        else $error("first trial is not msb");
endmodule

bind sac_top sac_chk i_sac_chk (
    .clk               (clk),
    .rst_n             (rst_n),
    .bus_req           (bus_req),
    .rd_data           (rd_data),
    .stop_mode         (stop_mode),
    .slow_mode         (slow_mode),
    .sleep_mode        (sleep_mode),
    .comp_in           (comp_in),
    .ana               (ana),
    .conv_complete_irq (conv_complete_irq)
);

`default_nettype wire

/* verification/sac_top_bench.sv */
// testbench: register-level tests of the converter control
`timescale 1ns/1ps
`default_nettype none

module sac_top_bench;
    import sac_pkg::*;
    // ------------------------------------------------------------
    // environment
    // ------------------------------------------------------------
    localparam logic [31:0] VOLTS = 32'hFE01_C35A;
    localparam logic [2:0]  CODES [6] = '{TC_39, TC_78, TC_156, TC_312, TC_624, TC_1248};
    localparam int          NS    [6] = '{39, 78, 156, 312, 624, 1248};

    logic         clk      = 1'b0;
    logic         rst_n    = 1'b0;
    sac_bus_req_t bus_req  = '0;
    logic [2:0]   lp_modes = 3'h0;
    logic [7:0]   rd_data;
    logic         comp_in;
    sac_ana_t     ana;
    logic         conv_complete_irq;
    int           failures        = 0;
    int           samples_checked = 0;
    int           cyc    = 0;
    int           irq_at = 0;
    int           t_wr   = 0;
    int           old;
    logic [7:0]   d;

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv_complete_irq === 1'b1) irq_at <= cyc;
        if (cyc > 20000) begin
            failures++;
            print_verdict();
        end
    end

    sac_top i_sac_top (
        .clk (clk), .rst_n (rst_n), .bus_req (bus_req), .rd_data (rd_data),
        .stop_mode (lp_modes[0]), .slow_mode (lp_modes[1]), .sleep_mode (lp_modes[2]),
        .comp_in (comp_in), .ana (ana), .conv_complete_irq (conv_complete_irq)
    );

    sac_ana_model #(.VOLTS (VOLTS)) i_sac_ana_model (
        .clk (clk), .rst_n (rst_n), .ana (ana), .comp_in (comp_in)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        t_wr = cyc;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(negedge clk);
        v = rd_data;
    endtask

    task automatic wait_irq(input int since);
        for (int i = 0; i < 1400 && irq_at == since; i++) @(posedge clk);
    endtask

    function automatic logic [7:0] volt(input int ch);
        return VOLTS[8*(ch-1) +: 8];
    endfunction

    task automatic convert(input int ch, input logic [2:0] code, input int n, input bit rb);
        int since;
        wr(OFF_CTRL_B, 8'h30 | {4'h0, code, 1'b0});
        wr(OFF_CTRL_A, 8'h20 | 8'(ch));
        since = irq_at;
        wr(OFF_CTRL_A, 8'hA0 | 8'(ch));
        rd(OFF_STATUS, d);
        check(d & 8'h30, 8'h10);
        rd(OFF_CTRL_A, d);
        check(d, 8'h20 | 8'(ch));
        wait_irq(since);
        check(16'(irq_at - t_wr), 16'(n + 3));
        if (rb) begin
            rd(OFF_STATUS, d);
            check(d & 8'h30, 8'h20);
            rd(OFF_RESULT, d);
            check(d, volt(ch));
            rd(OFF_STATUS, d);
            check(d & 8'h30, 8'h00);
        end
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_CTRL_A, d);
        check(d, 8'h10);
        rd(OFF_CTRL_B, d);
        check(d & 8'h3F, 8'h10);
        rd(OFF_RESULT, d);
        check(d, 8'h00);
        rd(OFF_STATUS, d);
        check(d & 8'h30, 8'h00);
        check(ana.inputs_off, 1'b1);
        wr(OFF_RESULT, 8'hFF);
        rd(OFF_RESULT, d);
        check(d, 8'h00);
        rd(8'h30, d);
        check(d, 8'h00);
        $display("test reset_values done");

        for (int i = 0; i < 6; i++) convert(i % 4 + 1, CODES[i], NS[i], 1'b1);
        $display("test time_codes done");

        // restart with an unread result: old value held until the new one lands
        convert(1, TC_78, 78, 1'b0);
        old = irq_at;
        wr(OFF_CTRL_A, 8'hA3);
        rd(OFF_STATUS, d);
        check(d & 8'h30, 8'h10);
        rd(OFF_RESULT, d);
        check(d, volt(1));
        wait_irq(old);
        rd(OFF_RESULT, d);
        check(d, volt(3));
        $display("test restart done");

        for (int m = 0; m < 3; m++) begin
            wr(OFF_CTRL_B, 8'h30 | {4'h0, TC_1248, 1'b0});
            wr(OFF_CTRL_A, 8'hA1);
            repeat (5) @(posedge clk);
            lp_modes <= 3'h1 << m;
            wr(OFF_CTRL_A, 8'h2F);
            wr(OFF_CTRL_B, 8'h3C);
            rd(OFF_CTRL_A, d);
            check(d, 8'h10);
            rd(OFF_CTRL_B, d);
            check(d & 8'h3F, 8'h10);
            rd(OFF_STATUS, d);
            check(d & 8'h30, 8'h00);
            @(posedge clk);
            lp_modes <= 3'h0;
            old = irq_at;
            repeat (1300) @(posedge clk);
            check(16'(irq_at - old), 16'h0000);
        end
        $display("test low_power done");
        print_verdict();
    end
endmodule

`default_nettype wire
